//--- hw/parallel_port_channel_config.sv
`timescale 1ns/1ps
`include "pp_cfg.svh"

// Function
// - Software reset bit set holds the engine in reset; registers keep their values.
// - Clearing enable finishes the DMA burst under way, then stops.
// - Realtime emulation bit set halts transactions while program halted.
// - Emulation halt stops only with soft stop 1 and free run 0.
// - B-to-A loopback valid only with A-to-B clear and mode 2h.
// - A-to-B loopback valid only with B-to-A clear and mode 3h.
// - Loopback moves data internally, no external pin wiring needed.
// - 9 to 15-bit widths reformat upper bits; 8/16-bit untouched.
// - Pack format: right zero, right sign, left zero-filled, reserved.
// - Bit width 0 means no packing, 1h..7h mean 9..15 bits.
// - Interface width bit selects 8-bit or 16-bit transfers.
// - Data rate bit selects single or double data rate.
// - DDR split: both DMA channels serve A; single channel, mode 0/1.
// - SDR transmit interleave: both DMA serve A; single channel, mode 1.
// - Channel count bit: A only when 0, A and B when 1.
// - Two-bit mode field sets direction of each active channel.
// - Modes: all rx, all tx, A rx B tx, A tx B rx; duplex dual.
// - DMA busy status bit is read-only, 1 while DMA active.
module parallel_port_channel_config (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic        wr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        dma_active_i,
  input  wire logic        emu_halt_i,
  input  wire logic [15:0] pin_rx_a_i,
  input  wire logic [15:0] pin_rx_b_i,
  input  wire logic [15:0] mem_tx_a_i,
  input  wire logic [15:0] mem_tx_b_i,
  output logic      [15:0] mem_rx_a_o,
  output logic      [15:0] mem_rx_b_o,
  output logic      [15:0] pin_tx_a_o,
  output logic      [15:0] pin_tx_b_o,
  output logic             periph_rst_o,
  output logic             run_o,
  output logic             chan_b_active_o,
  output logic             chan_a_tx_o,
  output logic             chan_b_tx_o,
  output logic             chan_a_bus_width_o,
  output logic             chan_b_bus_width_o,
  output logic             chan_a_rate_o,
  output logic             chan_b_rate_o,
  output logic             loop_b_to_a_o,
  output logic             loop_a_to_b_o,
  output logic             dma_q_serves_a_o
);

  pp_pkg::state_t st_q;
  pp_pkg::state_t st_d;

  logic        soft_reset_bit;
  logic        enable_bit;
  logic        realtime_emu_halt;
  logic        soft_stop;
  logic        free_run;
  logic [1:0]  op_mode;
  logic        channel_count_sel;
  logic        single_rate_tx_interleave;
  logic        double_rate_split;
  logic        chan_a_rate;
  logic        chan_a_bus_width;
  logic [2:0]  chan_a_bit_width;
  logic [1:0]  chan_a_pack_format;
  logic        chan_b_rate;
  logic        chan_b_bus_width;
  logic [2:0]  chan_b_bit_width;
  logic [1:0]  chan_b_pack_format;
  logic        loop_a_to_b;
  logic        loop_b_to_a;
  logic        emu_stop;
  logic        stop_req;
  logic        a_tx;
  logic        b_tx;
  logic [15:0] rx_raw_a;
  logic [15:0] rx_raw_b;
  logic [15:0] rx_fmt [2];
  logic [15:0] tx_fmt [2];
  logic [15:0] rx_src [2];
  logic [15:0] tx_src [2];
  logic        ch_bus16 [2];
  logic [2:0]  ch_width [2];
  logic [1:0]  ch_format [2];

  always_comb begin
    soft_reset_bit     = st_q.pcr[`PCR_SOFT_RST];
    enable_bit         = st_q.pcr[`PCR_EN];
    realtime_emu_halt  = st_q.pcr[`PCR_EMU_HALT];
    soft_stop          = st_q.pcr[`PCR_SOFT];
    free_run           = st_q.pcr[`PCR_FREE];
    op_mode            = st_q.ctl[`CTL_MODE_LO +: 2];
    channel_count_sel  = st_q.ctl[`CTL_CHAN_CNT];
    single_rate_tx_interleave = st_q.ctl[`CTL_TX_ILV];
    double_rate_split  = st_q.ctl[`CTL_DDRSPLIT];
    chan_a_rate        = st_q.ctl[`CTL_RATE_A];
    chan_a_bus_width   = st_q.ctl[`CTL_BUS16_A];
    chan_a_bit_width   = st_q.ctl[`CTL_WIDTH_A_LO +: 3];
    chan_a_pack_format = st_q.ctl[`CTL_FMT_A_LO +: 2];
    chan_b_rate        = st_q.ctl[`CTL_RATE_A + `CTL_B_SHIFT];
    chan_b_bus_width   = st_q.ctl[`CTL_BUS16_A + `CTL_B_SHIFT];
    chan_b_bit_width   = st_q.ctl[`CTL_WIDTH_A_LO + `CTL_B_SHIFT +: 3];
    chan_b_pack_format = st_q.ctl[`CTL_FMT_A_LO + `CTL_B_SHIFT +: 2];
    loop_a_to_b        = st_q.dlb[`DLB_A_TO_B];
    loop_b_to_a        = st_q.dlb[`DLB_B_TO_A];
  end

  // Direction per mode; B only counts in dual channel mode
  always_comb begin
    a_tx = 1'b0;
    b_tx = 1'b0;
    case (op_mode)
      `MODE_ALL_RX: begin
        a_tx = 1'b0;
        b_tx = 1'b0;
      end
      `MODE_ALL_TX: begin
        a_tx = 1'b1;
        b_tx = 1'b1;
      end
      `MODE_ARX_BTX: begin
        a_tx = 1'b0;
        b_tx = 1'b1;
      end
      `MODE_ATX_BRX: begin
        a_tx = 1'b1;
        b_tx = 1'b0;
      end
      default: begin
        a_tx = 1'b0;
        b_tx = 1'b0;
      end
    endcase
  end

  // Invalid loopback combinations simply have no effect
  assign loop_b_to_a_o = loop_b_to_a && !loop_a_to_b && channel_count_sel
                         && (op_mode == `MODE_ARX_BTX);
  assign loop_a_to_b_o = loop_a_to_b && !loop_b_to_a && channel_count_sel
                         && (op_mode == `MODE_ATX_BRX);

  // Loopback feeds the other channel's formatted word straight in
  always_comb begin
    rx_raw_a = loop_b_to_a_o ? st_q.tx_b : pin_rx_a_i;
    rx_raw_b = loop_a_to_b_o ? st_q.tx_a : pin_rx_b_i;
    rx_src[0]    = rx_raw_a;
    rx_src[1]    = rx_raw_b;
    tx_src[0]    = mem_tx_a_i;
    tx_src[1]    = mem_tx_b_i;
    ch_bus16[0]  = chan_a_bus_width;
    ch_bus16[1]  = chan_b_bus_width;
    ch_width[0]  = chan_a_bit_width;
    ch_width[1]  = chan_b_bit_width;
    ch_format[0] = chan_a_pack_format;
    ch_format[1] = chan_b_pack_format;
  end

  for (genvar c = 0; c < 2; c++) begin : g_chan
    word_formatter u_rx_fmt (
      .dir_tx_i      (1'b0),
      .bus16_i       (ch_bus16[c]),
      .bit_width_i   (ch_width[c]),
      .pack_format_i (ch_format[c]),
      .word_i        (rx_src[c]),
      .word_o        (rx_fmt[c])
    );
    word_formatter u_tx_fmt (
      .dir_tx_i      (1'b1),
      .bus16_i       (ch_bus16[c]),
      .bit_width_i   (ch_width[c]),
      .pack_format_i (ch_format[c]),
      .word_i        (tx_src[c]),
      .word_o        (tx_fmt[c])
    );
  end

  // Halt is stop only when all three debug settings agree
  assign emu_stop = st_q.halt_lvl && realtime_emu_halt
                    && soft_stop && !free_run;
  assign stop_req = !enable_bit || emu_stop;

  always_comb begin
    st_d = st_q;

    // Three-stage sync, level accepted when stages two and three agree
    st_d.halt_sync = {st_q.halt_sync[1:0], emu_halt_i};
    if (st_q.halt_sync[1] == st_q.halt_sync[2]) begin
      st_d.halt_lvl = st_q.halt_sync[2];
    end

    if (wr_i) begin
      case (addr_i)
        `PCR_OFS: st_d.pcr = wdata_i & `PCR_WMASK;
        `DLB_OFS: st_d.dlb = wdata_i & `DLB_WMASK;
        `CTL_OFS: st_d.ctl = wdata_i & `CTL_WMASK;
        default: st_d.pcr = st_q.pcr;
      endcase
    end

    st_d.rdata = `REG_RESET;
    if (rd_i) begin
      case (addr_i)
        `PCR_OFS: begin
          st_d.rdata = st_q.pcr;
          st_d.rdata[`PCR_DMA_BUSY] = dma_active_i;
        end
        `DLB_OFS: st_d.rdata = st_q.dlb;
        `CTL_OFS: st_d.rdata = st_q.ctl;
        default: st_d.rdata = `REG_RESET;
      endcase
    end

    // A burst already started completes before stopping, except under software reset
    case (st_q.run)
      pp_pkg::RUN_STOP: begin
        if (!stop_req) begin
          st_d.run = pp_pkg::RUN_GO;
        end
      end
      pp_pkg::RUN_GO: begin
        if (stop_req) begin
          st_d.run = dma_active_i ? pp_pkg::RUN_DRAIN
                                  : pp_pkg::RUN_STOP;
        end
      end
      pp_pkg::RUN_DRAIN: begin
        if (!dma_active_i) begin
          st_d.run = pp_pkg::RUN_STOP;
        end
      end
      default: st_d.run = pp_pkg::RUN_STOP;
    endcase

    // Words hold while stopped so the channel resumes where it left
    if (st_q.run != pp_pkg::RUN_STOP) begin
      st_d.rx_a = rx_fmt[0];
      st_d.rx_b = channel_count_sel ? rx_fmt[1] : st_q.rx_b;
      st_d.tx_a = tx_fmt[0];
      st_d.tx_b = channel_count_sel ? tx_fmt[1] : st_q.tx_b;
    end

    // Software reset clears the engine but keeps the registers
    if (soft_reset_bit) begin
      st_d.run  = pp_pkg::RUN_STOP;
      st_d.rx_a = '0;
      st_d.rx_b = '0;
      st_d.tx_a = '0;
      st_d.tx_b = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o            = st_q.rdata;
  assign mem_rx_a_o         = st_q.rx_a;
  assign mem_rx_b_o         = st_q.rx_b;
  assign pin_tx_a_o         = st_q.tx_a;
  assign pin_tx_b_o         = st_q.tx_b;
  assign periph_rst_o       = soft_reset_bit;
  assign run_o              = (st_q.run != pp_pkg::RUN_STOP)
                              && !soft_reset_bit;
  assign chan_b_active_o    = channel_count_sel;
  assign chan_a_tx_o        = a_tx;
  assign chan_b_tx_o        = b_tx && channel_count_sel;
  assign chan_a_bus_width_o = chan_a_bus_width;
  assign chan_b_bus_width_o = chan_b_bus_width;
  assign chan_a_rate_o      = chan_a_rate;
  assign chan_b_rate_o      = chan_b_rate;
  assign dma_q_serves_a_o   =
      (double_rate_split && chan_a_rate && !channel_count_sel
       && (op_mode == `MODE_ALL_RX || op_mode == `MODE_ALL_TX))
      || (single_rate_tx_interleave && !chan_a_rate
          && !channel_count_sel && (op_mode == `MODE_ALL_TX));

endmodule : parallel_port_channel_config

//--- hw/pp_cfg.svh
`ifndef PP_CFG_SVH
`define PP_CFG_SVH

// Register byte offsets
`define PCR_OFS        8'h04
`define DLB_OFS        8'h08
`define CTL_OFS        8'h10

// Peripheral control fields
`define PCR_FREE       0
`define PCR_SOFT       1
`define PCR_EMU_HALT   2
`define PCR_EN         3
`define PCR_SOFT_RST   4
`define PCR_DMA_BUSY   7
`define PCR_WMASK      32'h0000_001F

// Loopback control fields
`define DLB_A_TO_B     12
`define DLB_B_TO_A     13
`define DLB_WMASK      32'h0000_3000

// Channel control fields
`define CTL_MODE_LO    0
`define CTL_CHAN_CNT   2
`define CTL_TX_ILV     3
`define CTL_DDRSPLIT   4
`define CTL_RATE_A     16
`define CTL_BUS16_A    17
`define CTL_WIDTH_A_LO 18
`define CTL_FMT_A_LO   21
`define CTL_B_SHIFT    8
`define CTL_WMASK      32'h7F7F_001F

`define REG_RESET      32'h0000_0000

// Operating modes
`define MODE_ALL_RX    2'h0
`define MODE_ALL_TX    2'h1
`define MODE_ARX_BTX   2'h2
`define MODE_ATX_BRX   2'h3

// Packing formats
`define FMT_RJ_ZERO    2'h0
`define FMT_RJ_SIGN    2'h1
`define FMT_LJ_ZERO    2'h2

`define WIDTH_NONE     3'h0
`define WORD_ONES      16'hFFFF
`define SHIFT_BASE     4'h8

`endif

//--- hw/pp_pkg.sv
package pp_pkg;

  // Gray along stop -> run -> drain; drain -> stop flips both bits
  typedef enum logic [1:0] {
    RUN_STOP  = 2'b00,
    RUN_GO    = 2'b01,
    RUN_DRAIN = 2'b11
  } run_state_t;

  typedef struct packed {
    logic [31:0] pcr;
    logic [31:0] dlb;
    logic [31:0] ctl;
    run_state_t  run;
    logic [2:0]  halt_sync;
    logic        halt_lvl;
    logic [31:0] rdata;
    logic [15:0] rx_a;
    logic [15:0] rx_b;
    logic [15:0] tx_a;
    logic [15:0] tx_b;
  } state_t;

endpackage : pp_pkg

//--- hw/word_formatter.sv
`timescale 1ns/1ps
`include "pp_cfg.svh"

module word_formatter (
  input  wire logic        dir_tx_i,
  input  wire logic        bus16_i,
  input  wire logic [2:0]  bit_width_i,
  input  wire logic [1:0]  pack_format_i,
  input  wire logic [15:0] word_i,
  output logic      [15:0] word_o
);

  logic [3:0]  unused_bits;
  logic [15:0] keep_mask;
  logic        sign_bit;
  logic        active;

  always_comb begin
    unused_bits = `SHIFT_BASE - {1'b0, bit_width_i};
    keep_mask   = `WORD_ONES >> unused_bits;
    sign_bit    = |(word_i & ~(keep_mask >> 1) & keep_mask);
    // 8-bit, 16-bit and reserved format pass untouched
    active      = bus16_i && (bit_width_i != `WIDTH_NONE);
    word_o      = word_i;
    if (active) begin
      case (pack_format_i)
        `FMT_RJ_ZERO: word_o = word_i & keep_mask;
        `FMT_RJ_SIGN: begin
          if (dir_tx_i) begin
            word_o = word_i & keep_mask;
          end else begin
            word_o = sign_bit ? (word_i | ~keep_mask)
                              : (word_i & keep_mask);
          end
        end
        `FMT_LJ_ZERO: begin
          word_o = dir_tx_i ? (word_i >> unused_bits)
                            : (word_i << unused_bits);
        end
        default: word_o = word_i;
      endcase
    end
  end

endmodule : word_formatter

//--- verification/pp_chk.sv
`timescale 1ns/1ps
module pp_chk (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  addr_i,
  input wire logic        wr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        dma_active_i,
  input wire logic [15:0] pin_tx_a_o,
  input wire logic [15:0] mem_rx_b_o,
  input wire logic        periph_rst_o,
  input wire logic        run_o,
  input wire logic        chan_b_active_o,
  input wire logic        chan_a_tx_o,
  input wire logic        chan_b_tx_o,
  input wire logic        chan_b_bus_width_o,
  input wire logic        chan_a_rate_o,
  input wire logic        loop_b_to_a_o,
  input wire logic        loop_a_to_b_o,
  input wire logic        dma_q_serves_a_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_soft_reset_bit: assert property (
    wr_i && addr_i == 8'h04 |=> periph_rst_o == $past(wdata_i[4]))
    else $error("soft reset output does not follow control write");
  a_reset_holds_run: assert property (
    periph_rst_o |=> !run_o && pin_tx_a_o == 16'h0 && mem_rx_b_o == 16'h0)
    else $error("engine runs or keeps data while held in soft reset");
  a_stop_after_dma: assert property (
    $fell(run_o) && !periph_rst_o && !$past(periph_rst_o)
      |-> !$past(dma_active_i))
    else $error("engine stopped while a burst was active");
  a_rdata_idle: assert property (
    !rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  a_busy_flag_read: assert property (
    rd_i && addr_i == 8'h04 |=> rdata_o[7] == $past(dma_active_i)
      && rdata_o[31:8] == 24'h0 && rdata_o[6:5] == 2'h0)
    else $error("control read shows wrong busy or reserved bits");
  a_loop_b_a_valid: assert property (
    loop_b_to_a_o |-> chan_b_active_o && !chan_a_tx_o && chan_b_tx_o
      && !loop_a_to_b_o)
    else $error("B to A loopback outside its mode");
  a_loop_a_b_valid: assert property (
    loop_a_to_b_o |-> chan_b_active_o && chan_a_tx_o && !chan_b_tx_o)
    else $error("A to B loopback outside its mode");
  a_single_b_idle: assert property (
    !chan_b_active_o |-> !chan_b_tx_o)
    else $error("channel B transmits in single channel mode");
  a_single_b_hold: assert property (
    !chan_b_active_o && !periph_rst_o |=> $stable(mem_rx_b_o))
    else $error("channel B receive word moves in single channel mode");
  a_dma_both_a: assert property (
    dma_q_serves_a_o |-> !chan_b_active_o && (chan_a_rate_o || chan_a_tx_o))
    else $error("both DMA channels on A in an illegal setup");
  a_loop_data_path: assert property (
    loop_a_to_b_o && run_o && !chan_b_bus_width_o
      |=> mem_rx_b_o == $past(pin_tx_a_o))
    else $error("loopback word lost between channels");
endmodule : pp_chk

bind parallel_port_channel_config pp_chk u_chk (.clk_i, .rst_n_i, .addr_i,
  .wr_i, .wdata_i, .rd_i, .rdata_o, .dma_active_i, .pin_tx_a_o, .mem_rx_b_o,
  .periph_rst_o, .run_o, .chan_b_active_o, .chan_a_tx_o, .chan_b_tx_o,
  .chan_b_bus_width_o, .chan_a_rate_o, .loop_b_to_a_o, .loop_a_to_b_o,
  .dma_q_serves_a_o);

//--- verification/pp_far_end.sv
`timescale 1ns/1ps
module pp_far_end (
  input  wire logic        clk_i,
  input  wire logic        b_tx_i,
  input  wire logic [15:0] word_i,
  output logic      [15:0] rx_a_o,
  output logic      [15:0] rx_b_o
);
  initial rx_a_o = 16'h0;
  initial rx_b_o = 16'h0;
  // Released B line toggles so stale data never passes
  always @(negedge clk_i) begin
    rx_a_o <= word_i;
    rx_b_o <= b_tx_i ? ~rx_b_o : ~word_i;
  end
endmodule : pp_far_end

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic        dma_active_i = 1'b0, emu_halt_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, r, seed = 32'hA0B2FC1C;
  logic [15:0] mem_tx_a_i = 16'h0, mem_tx_b_i = 16'h0, word = 16'h0;
  logic [15:0] pin_rx_a_i, pin_rx_b_i, mem_rx_a_o, mem_rx_b_o;
  logic [15:0] pin_tx_a_o, pin_tx_b_o;
  logic        periph_rst_o, run_o, chan_b_active_o, chan_a_tx_o;
  logic        chan_b_tx_o, chan_a_bus_width_o, chan_b_bus_width_o;
  logic        chan_a_rate_o, chan_b_rate_o, loop_b_to_a_o, loop_a_to_b_o;
  logic        dma_q_serves_a_o;
  logic [31:0] mp = 32'h0, md = 32'h0, mc = 32'h0;
  logic [9:0]  s, e;
  logic [7:0]  a4 [4] = '{8'h04, 8'h08, 8'h10, 8'h0C};
  int          miscompares = 0, n_tests = 0, m;

  parallel_port_channel_config DUT (.clk_i, .rst_n_i, .addr_i, .wr_i,
    .wdata_i, .rd_i, .rdata_o, .dma_active_i, .emu_halt_i, .pin_rx_a_i,
    .pin_rx_b_i, .mem_tx_a_i, .mem_tx_b_i, .mem_rx_a_o, .mem_rx_b_o,
    .pin_tx_a_o, .pin_tx_b_o, .periph_rst_o, .run_o, .chan_b_active_o,
    .chan_a_tx_o, .chan_b_tx_o, .chan_a_bus_width_o, .chan_b_bus_width_o,
    .chan_a_rate_o, .chan_b_rate_o, .loop_b_to_a_o, .loop_a_to_b_o,
    .dma_q_serves_a_o);
  pp_far_end far (.clk_i, .b_tx_i(chan_b_tx_o), .word_i(word),
    .rx_a_o(pin_rx_a_i), .rx_b_o(pin_rx_b_i));

  always #20 clk_i = ~clk_i;

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // k packs bus16, format and width in bits 5, 4:3 and 2:0
  function automatic logic [15:0] fmt(input logic [15:0] x, input bit tx,
                                      input int k);
    int n;
    logic [15:0] mk;
    n = 8 + k[2:0];
    mk = 16'hFFFF >> (16 - n);
    if (!k[5] || k[2:0] == 0 || k[4:3] == 3) return x;
    if (k[4:3] == 2) return tx ? x >> (16 - n) : x << (16 - n);
    if (k[4:3] == 1 && !tx && x[n-1]) return x | ~mk;
    return x & mk;
  endfunction : fmt

  task automatic chk(input logic [31:0] sv, input logic [31:0] ev);
    n_tests++;
    if (sv !== ev) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, sv, ev);
    end
  endtask : chk

  task automatic results();
    $display("checks=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    if (a == 8'h04) mp = d & 32'h0000001F;
    if (a == 8'h08) md = d & 32'h00003000;
    if (a == 8'h10) mc = d & 32'h7F7F001F;
    @(negedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(negedge clk_i);
    rd_i <= 1'b0;
    r = a == 8'h04 ? mp | {24'h0, dma_active_i, 7'h0} : 32'h0;
    r = a == 8'h08 ? md : a == 8'h10 ? mc : r;
    chk(rdata_o, r);
  endtask : rd

  // About 660 cycles are needed; allow a wide margin
  initial begin
    #400000;
    miscompares++;
    results();
  end

  initial begin
    repeat (8) @(negedge clk_i);
    rst_n_i <= 1'b1;
    foreach (a4[i]) rd(a4[i]);
    repeat (16) begin
      m = rnd() % 4;
      r = rnd();
      dma_active_i <= r[0];
      wr(a4[m], rnd());
      rd(a4[m]);
    end
    repeat (48) begin
      wr(8'h10, rnd());
      wr(8'h08, rnd());
      m = mc[1:0];
      e = {mc[2], mc[0], mc[2] & (m == 1 || m == 2), mc[17], mc[25],
           mc[16], mc[24], md[13] & !md[12] & mc[2] & m == 2,
           md[12] & !md[13] & mc[2] & m == 3,
           !mc[2] & (mc[4] & mc[16] & m < 2 | mc[3] & !mc[16] & m == 1)};
      s = {chan_b_active_o, chan_a_tx_o, chan_b_tx_o, chan_a_bus_width_o,
           chan_b_bus_width_o, chan_a_rate_o, chan_b_rate_o, loop_b_to_a_o,
           loop_a_to_b_o, dma_q_serves_a_o};
      chk(32'(s), 32'(e));
    end
    dma_active_i <= 1'b0;
    wr(8'h04, 32'h08);
    for (int k = 0; k < 64; k++) begin
      wr(8'h10, 32'(k[4:3]) << 21 | 32'(k[2:0]) << 18 | 32'(k[5]) << 17);
      r = rnd();
      word <= r[15:0];
      mem_tx_a_i <= r[15:0];
      repeat (2) @(negedge clk_i);
      chk(32'(mem_rx_a_o), 32'(fmt(r[15:0], 0, k)));
      chk(32'(pin_tx_a_o), 32'(fmt(r[15:0], 1, k)));
    end
    wr(8'h10, 32'h07);
    wr(8'h08, 32'h1000);
    r = rnd();
    mem_tx_a_i <= r[15:0];
    mem_tx_b_i <= r[31:16];
    repeat (4) @(negedge clk_i);
    chk(32'(mem_rx_b_o), 32'(r[15:0]));
    wr(8'h10, 32'h06);
    wr(8'h08, 32'h2000);
    repeat (4) @(negedge clk_i);
    chk(32'(mem_rx_a_o), 32'(r[31:16]));
    chk(32'(pin_tx_b_o), 32'(r[31:16]));
    emu_halt_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr(8'h04, 32'(8 + i));
      repeat (8) @(negedge clk_i);
      chk(32'(run_o), 32'(i != 6));
    end
    emu_halt_i <= 1'b0;
    wr(8'h04, 32'h0E);
    repeat (8) @(negedge clk_i);
    chk(32'(run_o), 32'h1);
    dma_active_i <= 1'b1;
    wr(8'h04, 32'h00);
    repeat (5) @(negedge clk_i);
    chk(32'(run_o), 32'h1);
    dma_active_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk(32'(run_o), 32'h0);
    wr(8'h04, 32'h18);
    repeat (3) @(negedge clk_i);
    chk(32'({periph_rst_o, run_o}), 32'h2);
    rd(8'h04);
    wr(8'h04, 32'h08);
    repeat (3) @(negedge clk_i);
    chk(32'({periph_rst_o, run_o}), 32'h1);
    results();
  end
endmodule : testbench
